// ==== src/i2cm_regs.svh ====
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
// What this block does
// R1 - write sends the programmed data byte third, after address and pointer
// R2 - in manual mode software loads next byte only after the ack interrupt
// R3 - data register holds no valid read data before a start
// R4 - received byte is in the data register when the ack interrupt rises
// R5 - data read before stop triggers another byte read on the bus
// R6 - data read after stop returns the byte and starts nothing
// R7 - write sends the 8-bit register pointer right after the address byte
// R8 - writing one to command bit 1 makes a stop condition
// R9 - writing one to command bit 0 starts, sends address, then data
// R10 - peripheral address: identifier in bits 7-1, bit 0 one means read
// R11 - programmable gap after address, between bytes, before stop
// R12 - slave holding clock low pauses the master until release
// R13 - start and stop bits are pulses; writing zero does nothing
// R14 - ack interrupt after each acknowledged byte transfer
`define I2CM_A_GAP   8'h14
`define I2CM_A_PADR  8'h18
`define I2CM_A_DATA  8'h1c
`define I2CM_A_PTR   8'h20
`define I2CM_A_CMD   8'h24
`define I2CM_A_MODE  8'h28
`define I2CM_A_STS   8'h2c
`define I2CM_A_MSK   8'h30
`define I2CM_A_STATE 8'h34
`define I2CM_B_START 0
`define I2CM_B_STOP  1
`define I2CM_B_DIR   0
`define I2CM_B_MAN   16
`define I2CM_GAP_HI  31
`define I2CM_GAP_LO  16
`define I2CM_ST_ACK  0
`define I2CM_ST_NACK 1
`define I2CM_ST_DONE 2
`define I2CM_DIV_RST 16'h00fa
`define I2CM_BITS    4'h8
`define I2CM_LAST    4'h7
`define I2CM_PH_ADR  2'h0
`define I2CM_PH_PTR  2'h1
`define I2CM_PH_DAT  2'h2
`endif

// ==== src/i2cm_pkg.sv ====
package i2cm_pkg;
  typedef logic [7:0] i2cm_addr_t;
  typedef logic [31:0] i2cm_word_t;
  typedef enum logic [7:0] {
    st_idle  = 8'h01,
    st_start = 8'h02,
    st_lo    = 8'h04,
    st_hi    = 8'h08,
    st_gap   = 8'h10,
    st_hold  = 8'h20,
    st_stop  = 8'h40,
    st_stop2 = 8'h80
  } i2cm_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_pins_t;
  typedef struct packed {
    i2cm_state_t st;
    logic [15:0] cnt;
    logic [3:0]  bitc;
    logic [1:0]  ph;
    logic [7:0]  sh;
    logic [7:0]  data;
    logic [7:0]  ptr;
    logic [7:0]  padr;
    logic [15:0] gap;
    logic [15:0] div;
    logic        manual;
    logic        stop_pend;
    logic        rd_pend;
    logic        wr_pend;
    logic        mack;
    logic [2:0]  sts;
    logic [2:0]  msk;
    logic        scl_low;
    logic        sda_low;
    i2cm_word_t  prdata;
  } i2cm_core_t;
endpackage : i2cm_pkg

// ==== src/i2cm_sync.sv ====
`timescale 1ns/1ps
module i2cm_sync (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire i2cm_pkg::i2cm_pins_t d,
  output      i2cm_pkg::i2cm_pins_t q
);
  import i2cm_pkg::*;
  typedef struct packed {
    i2cm_pins_t meta;
    i2cm_pins_t sync;
  } i2cm_sync_t;
  i2cm_sync_t s_r;
  i2cm_sync_t s_nxt;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end
  // idle bus reads high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r.sync;
endmodule : i2cm_sync

// ==== src/i2cm_top.sv ====
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "i2cm_regs.svh"
module i2cm_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire i2cm_pkg::i2cm_addr_t paddr,
  input  wire i2cm_pkg::i2cm_word_t pwdata,
  output      i2cm_pkg::i2cm_word_t prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              scl_i,
  output      logic              scl_o,
  output      logic              scl_oe_n,
  input  wire logic              sda_i,
  output      logic              sda_o,
  output      logic              sda_oe_n,
  output      logic              irq
);
  import i2cm_pkg::*;

  i2cm_core_t s_r;
  i2cm_core_t s_nxt;
  i2cm_pins_t pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       setup;
  logic       acc_wr;
  logic       acc_rd;
  logic       cmd_start;
  logic       cmd_stop;
  logic       busy;
  logic       rx;
  logic       tick;

  i2cm_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_i, sda_i}),
    .q     (pin_s)
  );
  assign scl_s = pin_s.scl;
  assign sda_s = pin_s.sda;

  function automatic logic mapped(input i2cm_addr_t a);
    case (a)
      `I2CM_A_GAP, `I2CM_A_PADR, `I2CM_A_DATA, `I2CM_A_PTR, `I2CM_A_CMD,
      `I2CM_A_MODE, `I2CM_A_STS, `I2CM_A_MSK, `I2CM_A_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic i2cm_word_t read_word(input i2cm_core_t c, input i2cm_addr_t a);
    read_word = 32'h0;
    case (a)
      `I2CM_A_GAP:   read_word[`I2CM_GAP_HI:`I2CM_GAP_LO] = c.gap;
      `I2CM_A_PADR:  read_word[7:0] = c.padr;
      // last written or last received byte
      `I2CM_A_DATA:  read_word[7:0] = c.data; // R3
      `I2CM_A_PTR:   read_word[7:0] = c.ptr;
      `I2CM_A_MODE:  read_word = {15'h0, c.manual, c.div};
      `I2CM_A_STS:   read_word[2:0] = c.sts;
      `I2CM_A_MSK:   read_word[2:0] = c.msk;
      `I2CM_A_STATE: read_word[8:0] = {c.st != st_idle, c.st};
      default:       read_word = 32'h0;
    endcase
  endfunction : read_word

  // one to pull the data line low for the bit about to be clocked
  function automatic logic drive_bit(input logic rxm, input logic [3:0] b,
                                     input logic [7:0] v, input logic ma);
    if (b == `I2CM_BITS) begin
      drive_bit = rxm ? !ma : 1'b0;
    end else begin
      drive_bit = rxm ? 1'b0 : !v[7];
    end
  endfunction : drive_bit

  assign setup     = psel && !penable;
  assign acc_wr    = psel && penable && pwrite;
  assign acc_rd    = psel && penable && !pwrite;
  assign cmd_start = acc_wr && paddr == `I2CM_A_CMD && pwdata[`I2CM_B_START]; // R13
  assign cmd_stop  = acc_wr && paddr == `I2CM_A_CMD && pwdata[`I2CM_B_STOP];  // R13
  assign busy      = s_r.st != st_idle;
  assign rx        = s_r.padr[`I2CM_B_DIR] && s_r.ph != `I2CM_PH_ADR; // R10
  assign tick      = s_r.cnt == 16'h0;

  always_comb begin
    s_nxt = s_r;
    // apb side
    if (setup) begin
      s_nxt.prdata = read_word(s_r, paddr);
    end
    if (acc_wr) begin
      case (paddr)
        `I2CM_A_GAP:  s_nxt.gap = pwdata[`I2CM_GAP_HI:`I2CM_GAP_LO];
        `I2CM_A_PADR: s_nxt.padr = pwdata[7:0];
        `I2CM_A_DATA: begin
          s_nxt.data    = pwdata[7:0];
          s_nxt.wr_pend = busy;
        end
        `I2CM_A_PTR:  s_nxt.ptr = pwdata[7:0];
        `I2CM_A_MODE: begin
          s_nxt.div    = pwdata[15:0];
          s_nxt.manual = pwdata[`I2CM_B_MAN];
        end
        `I2CM_A_MSK:  s_nxt.msk = pwdata[2:0];
        default: ;
      endcase
    end
    if (acc_rd && paddr == `I2CM_A_DATA && busy && !s_r.stop_pend) begin
      s_nxt.rd_pend = 1'b1; // R5 R6
    end
    // clear only what this read reported, so an event in the access cycle survives
    if (acc_rd && paddr == `I2CM_A_STS) begin
      s_nxt.sts = s_r.sts & ~s_r.prdata[2:0];
    end
    if (cmd_stop && busy) begin
      s_nxt.stop_pend = 1'b1; // R8
    end
    // bus engine
    case (s_r.st)
      st_idle: begin
        if (cmd_start) begin
          s_nxt.st        = st_start; // R9
          s_nxt.sda_low   = 1'b1;
          s_nxt.cnt       = s_r.div;
          s_nxt.sh        = s_r.padr;
          s_nxt.ph        = `I2CM_PH_ADR;
          s_nxt.bitc      = 4'h0;
          s_nxt.stop_pend = cmd_stop;
          s_nxt.rd_pend   = 1'b0;
          s_nxt.wr_pend   = 1'b0;
        end
      end
      st_start: begin
        if (tick) begin
          s_nxt.scl_low = 1'b1;
          s_nxt.st      = st_lo;
          s_nxt.cnt     = s_r.div;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end
      end
      st_lo: begin
        if (s_r.cnt == s_r.div) begin
          s_nxt.sda_low = drive_bit(rx, s_r.bitc, s_r.sh, s_r.mack);
        end
        if (tick) begin
          s_nxt.scl_low = 1'b0;
          s_nxt.st      = st_hi;
          s_nxt.cnt     = s_r.div;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end
      end
      st_hi: begin
        if (!scl_s) begin
          s_nxt.cnt = s_r.cnt; // R12
        end else if (!tick) begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end else begin
          s_nxt.scl_low = 1'b1;
          s_nxt.cnt     = s_r.div;
          s_nxt.st      = st_lo;
          if (s_r.bitc != `I2CM_BITS) begin
            s_nxt.sh   = {s_r.sh[6:0], sda_s};
            s_nxt.bitc = s_r.bitc + 4'h1;
            if (rx && s_r.bitc == `I2CM_LAST) begin
              s_nxt.data               = {s_r.sh[6:0], sda_s}; // R4
              s_nxt.sts[`I2CM_ST_ACK]  = 1'b1;                 // R14
              s_nxt.st                 = st_gap;
              s_nxt.cnt                = s_r.gap;              // R11
            end
          end else begin
            s_nxt.bitc = 4'h0;
            s_nxt.st   = st_gap;
            s_nxt.cnt  = s_r.gap; // R11
            if (!rx && sda_s) begin
              s_nxt.sts[`I2CM_ST_NACK] = 1'b1;
              s_nxt.stop_pend          = 1'b1;
            end else if (!rx) begin
              s_nxt.sts[`I2CM_ST_ACK] = 1'b1; // R14
            end
          end
        end
      end
      st_gap: begin
        if (!tick) begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end else if (rx && s_r.bitc == `I2CM_BITS) begin
          s_nxt.st = st_hold;
        end else if (s_r.stop_pend) begin
          s_nxt.st = st_stop;
        end else begin
          s_nxt.st  = st_lo;
          s_nxt.cnt = s_r.div;
          case (s_r.ph)
            `I2CM_PH_ADR: begin
              if (s_r.padr[`I2CM_B_DIR]) begin
                s_nxt.ph = `I2CM_PH_DAT;
              end else begin
                s_nxt.ph = `I2CM_PH_PTR;
                s_nxt.sh = s_r.ptr; // R7
              end
            end
            `I2CM_PH_PTR: begin
              s_nxt.ph = `I2CM_PH_DAT;
              s_nxt.sh = s_r.data; // R1
            end
            default: begin
              if (!rx && s_r.manual) begin
                s_nxt.st = st_hold; // R2
              end else if (!rx) begin
                s_nxt.stop_pend = 1'b1;
                s_nxt.st        = st_stop;
              end
            end
          endcase
        end
      end
      st_hold: begin
        if (rx && s_r.stop_pend) begin
          s_nxt.mack    = 1'b1; // R6
          s_nxt.rd_pend = 1'b0;
          s_nxt.st      = st_lo;
          s_nxt.cnt     = s_r.div;
        end else if (rx && s_r.rd_pend) begin
          s_nxt.mack    = 1'b0; // R5
          s_nxt.rd_pend = 1'b0;
          s_nxt.st      = st_lo;
          s_nxt.cnt     = s_r.div;
        end else if (!rx && s_r.stop_pend) begin
          s_nxt.st = st_stop; // R8
        end else if (!rx && s_r.wr_pend) begin
          s_nxt.wr_pend = 1'b0;
          s_nxt.sh      = s_r.data; // R1
          s_nxt.bitc    = 4'h0;
          s_nxt.st      = st_lo;
          s_nxt.cnt     = s_r.div;
        end
      end
      st_stop: begin
        s_nxt.sda_low = 1'b1;
        if (s_r.sda_low && tick) begin
          s_nxt.scl_low = 1'b0;
          s_nxt.st      = st_stop2;
          s_nxt.cnt     = s_r.div;
        end else if (s_r.sda_low) begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end else begin
          s_nxt.cnt = s_r.div;
        end
      end
      st_stop2: begin
        if (!scl_s) begin
          s_nxt.cnt = s_r.cnt; // R12
        end else if (!tick) begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end else begin
          s_nxt.sda_low             = 1'b0; // R8
          s_nxt.stop_pend           = 1'b0;
          s_nxt.st                  = st_idle;
          s_nxt.sts[`I2CM_ST_DONE]  = 1'b1;
        end
      end
      default: begin
        s_nxt.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.st     <= st_idle;
      s_r.div    <= `I2CM_DIV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata   = s_r.prdata;
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = !s_r.scl_low;
  assign sda_oe_n = !s_r.sda_low;
  assign irq      = |(s_r.sts & s_r.msk);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rx_last;
    s_r.st == st_hi && rx && s_r.bitc == `I2CM_LAST && scl_s && tick;
  endsequence
  sequence s_hold_rd;
    s_r.st == st_hold && rx && s_r.rd_pend && !s_r.stop_pend;
  endsequence
  sequence s_gap_to_data;
    s_r.st == st_gap && tick && s_r.ph == `I2CM_PH_PTR && !s_r.stop_pend;
  endsequence

  a_start_cmd: assert property ( // R9
    s_r.st == st_idle && cmd_start |=> s_r.st == st_start && s_r.sda_low)
    else $error("start command did not begin a start");
  a_zero_cmd: assert property ( // R13
    s_r.st == st_idle && acc_wr && paddr == `I2CM_A_CMD && !pwdata[`I2CM_B_START]
    |=> s_r.st == st_idle)
    else $error("zero command bit left idle");
  a_stop_hold: assert property ( // R8
    s_r.st == st_hold && !rx && cmd_stop |=> ##1 s_r.st == st_stop)
    else $error("stop command ignored in hold");
  a_read_trig: assert property ( // R5
    s_hold_rd |=> s_r.st == st_lo && !s_r.mack && !s_r.rd_pend)
    else $error("data read did not trigger a byte read");
  a_read_quiet: assert property ( // R6
    acc_rd && paddr == `I2CM_A_DATA && (s_r.stop_pend || !busy) |=> !$rose(s_r.rd_pend))
    else $error("read after stop started bus activity");
  a_stretch_wait: assert property ( // R12
    s_r.st == st_hi && !scl_s |=> s_r.st == st_hi && $stable(s_r.cnt))
    else $error("clock stretch not honoured");
  a_gap_count: assert property ( // R11
    s_r.st == st_gap && !tick |=> s_r.st == st_gap && s_r.cnt == $past(s_r.cnt) - 16'h1)
    else $error("gap ended early");
  a_data_third: assert property ( // R1
    s_gap_to_data |=> s_r.sh == $past(s_r.data) && s_r.ph == `I2CM_PH_DAT)
    else $error("data byte not sent after pointer");
  a_ptr_first: assert property ( // R7
    s_r.st == st_gap && tick && s_r.ph == `I2CM_PH_ADR && !s_r.padr[`I2CM_B_DIR]
    && !s_r.stop_pend |=> s_r.sh == $past(s_r.ptr))
    else $error("pointer byte not sent after address");
  a_rx_valid: assert property ( // R4
    s_rx_last |=> s_r.data[7:1] == $past(s_r.sh[6:0]) && s_r.data[0] == $past(sda_s)
    && s_r.sts[`I2CM_ST_ACK])
    else $error("read data not valid at ack interrupt");
endmodule : i2cm_top

// ==== verification/i2cm_slave_model.sv ====
`timescale 1ns/1ps
module i2cm_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  input  wire logic       stretch,
  output logic            scl_low,
  output logic            sda_low,
  output logic [7:0]      rx_byte,
  output logic [7:0]      rx_cnt
);
  logic [7:0] sh;
  logic [7:0] nb;
  logic       rd;
  logic       mack;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    rx_cnt  = 8'h00;
  end
  task automatic take_byte();
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
    rx_byte = sh;
    rx_cnt  = rx_cnt + 8'h01;
    @(negedge scl);
    sda_low = 1'b1;
    if (stretch) begin
      scl_low = 1'b1;
      #200;
      scl_low = 1'b0;
    end
    @(negedge scl);
    sda_low = 1'b0;
  endtask : take_byte
  task automatic give_byte();
    for (int i = 7; i >= 0; i--) begin
      #1;
      sda_low = ~nb[i];
      @(posedge scl);
      @(negedge scl);
    end
    sda_low = 1'b0;
    rx_byte = nb;
    rx_cnt  = rx_cnt + 8'h01;
    nb      = nb + 8'h01;
    @(posedge scl);
    mack = sda;
    @(negedge scl);
    if (mack)
      forever @(negedge scl);
  endtask : give_byte
  task automatic frame();
    nb = rd_byte;
    take_byte();
    rd = sh[0];
    forever begin
      if (rd)
        give_byte();
      else
        take_byte();
    end
  endtask : frame
  // a stop condition ends whatever frame is in progress
  always begin
    @(negedge sda iff scl === 1'b1);
    fork
      frame();
      @(posedge sda iff scl === 1'b1);
    join_any
    disable fork;
    sda_low = 1'b0;
    scl_low = 1'b0;
  end
endmodule : i2cm_slave_model

// ==== verification/i2c_master_transfer_control_tb.sv ====
`timescale 1ns/1ps
`include "i2cm_regs.svh"
module i2c_master_transfer_control_tb;
  import i2cm_pkg::*;
  logic       pclk = 1'b0;
  logic       presetn = 1'b0;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  i2cm_addr_t paddr = 8'h00;
  i2cm_word_t pwdata = 32'h0;
  i2cm_word_t prdata;
  i2cm_word_t rv;
  logic       pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, irq;
  logic       s_scl_low, s_sda_low;
  logic       stretch = 1'b0;
  logic [7:0] rx_byte, rx_cnt;
  logic [7:0] rb = 8'h00;
  logic [31:0] seed = 32'h4e62;
  logic [7:0] exp_q[$];
  int         miscompares = 0;
  int         num_checks = 0;
  int         n_stop = 0;
  int         n_scl = 0;
  wire        scl_w = (scl_oe_n ? 1'b1 : scl_o) & ~s_scl_low;
  wire        sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~s_sda_low;
  always #2.5 pclk = ~pclk;
  i2cm_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .irq(irq)
  );
  i2cm_slave_model slave (
    .scl(scl_w), .sda(sda_w), .rd_byte(rb), .stretch(stretch), .scl_low(s_scl_low),
    .sda_low(s_sda_low), .rx_byte(rx_byte), .rx_cnt(rx_cnt)
  );
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input i2cm_addr_t a, input i2cm_word_t d, output logic e);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rv = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 0, 1);
      conclude();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input i2cm_addr_t a, input i2cm_word_t d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr
  task automatic rd(input i2cm_addr_t a);
    logic e;
    apb(1'b0, a, 32'h0, e);
  endtask : rd
  task automatic wait_st(input logic [7:0] c);
    int k;
    k = 0;
    do begin
      rd(`I2CM_A_STATE);
      k++;
    end while (rv[7:0] !== c && k < 3000);
    chk("state", {24'h0, rv[7:0]}, {24'h0, c});
    if (rv[7:0] !== c)
      conclude();
  endtask : wait_st
  task automatic wait_irq();
    int k;
    for (k = 0; k < 3000 && irq !== 1'b1; k++)
      @(posedge pclk);
    chk("irq wait", irq, 1);
    if (irq !== 1'b1)
      conclude();
  endtask : wait_irq
  task automatic wait_q();
    int k;
    for (k = 0; k < 5000 && exp_q.size() != 0; k++)
      @(posedge pclk);
    chk("bytes left", exp_q.size(), 0);
    if (exp_q.size() != 0)
      conclude();
  endtask : wait_q
  always @(rx_cnt)
    if (rx_cnt !== 8'h00)
      chk("bus byte", {24'h0, rx_byte}, exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h100);
  always @(posedge sda_w)
    if (scl_w === 1'b1)
      n_stop++;
  always @(negedge scl_w)
    n_scl++;
  initial begin
    logic [7:0] id, p, d;
    logic       e;
    int         k;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`I2CM_A_DATA);
    chk("data reset", rv, 32'h0);
    rd(`I2CM_A_PTR);
    chk("pointer reset", rv, 32'h0);
    rd(`I2CM_A_CMD);
    chk("command read", rv, 32'h0);
    rd(`I2CM_A_MODE);
    chk("mode reset", rv, 32'h0000_00fa);
    apb(1'b1, 8'h40, 32'hffff_ffff, e);
    chk("unmapped err", e, 1);
    apb(1'b0, 8'h40, 32'h0, e);
    chk("unmapped read", rv, 32'h0);
    wr(`I2CM_A_CMD, 32'h0);
    wr(`I2CM_A_CMD, 32'h2);
    rd(`I2CM_A_STATE);
    chk("idle state", rv[8:0], 9'h001);
    $display("test registers done");
    id = xs();
    p  = xs();
    d  = xs();
    wr(`I2CM_A_GAP, 32'h0003_0000);
    wr(`I2CM_A_MODE, 32'h0000_0005);
    wr(`I2CM_A_MSK, 32'h0);
    wr(`I2CM_A_PADR, {24'h0, id[6:0], 1'b0});
    wr(`I2CM_A_PTR, {24'h0, p});
    wr(`I2CM_A_DATA, {24'h0, d});
    exp_q = '{{id[6:0], 1'b0}, p, d};
    k = n_stop;
    wr(`I2CM_A_CMD, 32'h1);
    wait_st(8'h01);
    wait_q();
    chk("stop count", n_stop, k + 1);
    chk("irq masked", irq, 0);
    wr(`I2CM_A_MSK, 32'h7);
    chk("irq", irq, 1);
    rd(`I2CM_A_STS);
    chk("status", rv, 32'h5);
    chk("irq cleared", irq, 0);
    $display("test auto write done");
    stretch <= 1'b1;
    wr(`I2CM_A_MODE, 32'h0001_0005);
    exp_q = '{{id[6:0], 1'b0}, p, d};
    wr(`I2CM_A_CMD, 32'h1);
    wait_q();
    wait_st(8'h20);
    d = xs();
    exp_q.push_back(d);
    wr(`I2CM_A_DATA, {24'h0, d});
    wait_q();
    wait_st(8'h20);
    k = n_stop;
    wr(`I2CM_A_CMD, 32'h2);
    wait_st(8'h01);
    chk("stop count", n_stop, k + 1);
    stretch <= 1'b0;
    rd(`I2CM_A_STS);
    chk("manual status", rv, 32'h5);
    $display("test manual write done");
    rb = xs();
    wr(`I2CM_A_PADR, {24'h0, id[6:0], 1'b1});
    exp_q = '{{id[6:0], 1'b1}, rb};
    wr(`I2CM_A_CMD, 32'h1);
    wait_irq();
    rd(`I2CM_A_STS);
    chk("address ack", rv, 32'h1);
    wait_irq();
    exp_q.push_back(rb + 8'h01);
    rd(`I2CM_A_DATA);
    chk("read data", rv, {24'h0, rb});
    wait_q();
    wait_st(8'h20);
    k = n_stop;
    wr(`I2CM_A_CMD, 32'h2);
    rd(`I2CM_A_DATA);
    chk("stop data", rv, {24'h0, rb + 8'h01});
    wait_st(8'h01);
    chk("stop count", n_stop, k + 1);
    k = n_scl;
    rd(`I2CM_A_DATA);
    chk("final data", rv, {24'h0, rb + 8'h01});
    repeat (100) @(posedge pclk);
    chk("bus quiet", n_scl, k);
    $display("test read done");
    conclude();
  end
endmodule : i2c_master_transfer_control_tb
